//--- design/issd_decode.sv
// decoder/execute for partial stores, barrier, trap and exclusive-or
`timescale 1ns/1ns
module issd_decode
  import issd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] instr_pc,
  input  wire logic [31:0] rs_value,
  input  wire logic [31:0] rt_value,
  input  wire logic [1:0]  paddr_low,
  input  wire logic        cpu_big_endian_flag,
  input  wire logic        reverse_endian_flag,
  input  wire logic        memory_big_endian_flag,
  input  wire logic        mem_ops_pending,
  input  wire logic        store_ready,
  output logic             instr_ready,
  output logic             gpr_we,
  output logic [4:0]       gpr_waddr,
  output logic [31:0]      gpr_wdata,
  output logic             store_valid,
  output logic [31:0]      store_vaddr,
  output logic [1:0]       store_paddr_low,
  output logic [31:0]      store_data,
  output logic [3:0]       store_byte_en,
  output logic [2:0]       store_size,
  output logic             exc_valid,
  output issd_pkg::issd_exc_t exc_code,
  output logic [31:0]      exception_return_pc
);
  import issd_pkg::*;

  typedef enum logic [2:0] {
    ISSD_IDLE  = 3'b001,
    ISSD_SYNC  = 3'b010,
    ISSD_STORE = 3'b100
  } issd_state_t;

  issd_state_t state_reg, state_next;
  logic        ready_reg, ready_next;
  logic        we_reg, we_next;
  logic [4:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        sv_reg, sv_next;
  logic [31:0] va_reg, va_next;
  logic [1:0]  pa_reg, pa_next;
  logic [31:0] sd_reg, sd_next;
  logic [3:0]  be_reg, be_next;
  logic [2:0]  sz_reg, sz_next;
  logic        ev_reg, ev_next;
  issd_exc_t   ec_reg, ec_next;
  logic [31:0] epc_reg, epc_next;

  logic [5:0]  opcode;
  logic [5:0]  fn;
  logic [31:0] eff_addr;
  logic [1:0]  byte_idx;
  logic [1:0]  phys_low;
  logic        is_store_left;
  logic        is_store_right;
  logic        is_reserved;
  logic [31:0] al_data;
  logic [3:0]  al_be;
  logic [2:0]  al_size;
  // decoded requests of the instruction taken this edge
  logic        take;
  logic        func_op;
  logic        do_rsv;
  logic        do_trap;
  logic        do_barrier;
  logic        do_xor_reg;
  logic        do_xor_imm;
  logic        do_store;

  // sign-extend a 16-bit field
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  // pick a 5-bit register number starting at bit lo
  function automatic logic [4:0] reg_field(input logic [31:0] w,
                                           input int          lo);
    reg_field = w[lo +: 5];
  endfunction : reg_field

  // field decode from row/column of the primary map and function bits
  assign opcode = instr[OP_HI:OP_LO];
  assign fn     = instr[FN_HI:FN_LO];
  assign is_store_left  = (opcode == OP_STORE_LEFT);
  assign is_store_right = (opcode == OP_STORE_RIGHT);

  // effective address may point at any byte; no alignment check exists
  assign eff_addr = rs_value + sext16(instr[15:0]);
  assign byte_idx = eff_addr[1:0] ^ {2{cpu_big_endian_flag}};

  // physical low bits: reverse-endian swap, cleared for little memory
  assign phys_low = memory_big_endian_flag
                  ? (paddr_low ^ {2{reverse_endian_flag}})
                  : 2'h0;

  // reserved-encoding classification
  issd_reserved_check u_rsv (
    .instr    (instr),
    .reserved (is_reserved)
  );

  // lane steering keeps the store inside one aligned word
  issd_store_align u_align (
    .is_left  (is_store_left),
    .byte_idx (byte_idx),
    .src      (rt_value),
    .data     (al_data),
    .byte_en  (al_be),
    .size     (al_size)
  );

  // what the instruction taken at this edge asks for; reserved wins
  assign take       = instr_valid && ready_reg && (state_reg == ISSD_IDLE);
  assign func_op    = take && !is_reserved && (opcode == OP_FUNC_GROUP);
  assign do_rsv     = take && is_reserved;
  assign do_trap    = func_op && (fn == FN_SYS_TRAP);
  assign do_barrier = func_op && (fn == FN_BARRIER);
  assign do_xor_reg = func_op && (fn == FN_XOR_REG);
  assign do_xor_imm = take && !is_reserved && (opcode == OP_XOR_IMM);
  assign do_store   = take && !is_reserved &&
                      (is_store_left || is_store_right);

  // sequencing and store request next values
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    sv_next    = sv_reg;
    va_next    = va_reg;
    pa_next    = pa_reg;
    sd_next    = sd_reg;
    be_next    = be_reg;
    sz_next    = sz_reg;
    case (state_reg)
      ISSD_IDLE: begin
        ready_next = 1'b1;
        if (do_barrier) begin
          // no privilege check on the barrier
          state_next = ISSD_SYNC;
          ready_next = 1'b0;
        end else if (do_store) begin
          // one write, byte enables confine it to one word
          sv_next    = 1'b1;
          va_next    = eff_addr;
          pa_next    = phys_low;
          sd_next    = al_data;
          be_next    = al_be;
          sz_next    = al_size;
          state_next = ISSD_STORE;
          ready_next = 1'b0;
        end
        // loads and other ops proceed without waiting on memory
      end
      ISSD_SYNC: begin
        // hold later instructions until memory has drained
        if (!mem_ops_pending) begin
          state_next = ISSD_IDLE;
          ready_next = 1'b1;
        end
      end
      ISSD_STORE: begin
        // the request stands until the memory path accepts it
        if (store_ready) begin
          sv_next    = 1'b0;
          state_next = ISSD_IDLE;
          ready_next = 1'b1;
        end
      end
      default: begin
        // illegal state: back to idle, refuse for one cycle
        state_next = ISSD_IDLE;
        ready_next = 1'b0;
        sv_next    = 1'b0;
      end
    endcase
  end

  // sequencing and store request registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ISSD_IDLE;
      ready_reg <= 1'b0;
      sv_reg    <= 1'b0;
      va_reg    <= 32'h0000_0000;
      pa_reg    <= 2'h0;
      sd_reg    <= 32'h0000_0000;
      be_reg    <= 4'h0;
      sz_reg    <= 3'h0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      sv_reg    <= sv_next;
      va_reg    <= va_next;
      pa_reg    <= pa_next;
      sd_reg    <= sd_next;
      be_reg    <= be_next;
      sz_reg    <= sz_next;
    end
  end

  // write-back: one-cycle strobe, trapping instructions never write
  always_comb begin
    we_next    = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    if (do_xor_reg) begin
      we_next    = 1'b1;
      waddr_next = reg_field(instr, RD_LO);
      wdata_next = rs_value ^ rt_value;
    end else if (do_xor_imm) begin
      we_next    = 1'b1;
      waddr_next = reg_field(instr, RT_LO);
      wdata_next = rs_value ^ {16'h0000, instr[15:0]};
    end
  end

  // write-back registers
  always_ff @(posedge clock) begin
    if (srst) begin
      we_reg    <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
    end else begin
      we_reg    <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  // exception strobe, cause and the trapping instruction's address
  always_comb begin
    ev_next  = 1'b0;
    ec_next  = ISSD_EXC_NONE;
    epc_next = epc_reg;
    if (do_rsv) begin
      ev_next  = 1'b1;
      ec_next  = ISSD_EXC_RESERVED;
      epc_next = instr_pc;
    end else if (do_trap) begin
      // code field is not forwarded anywhere
      ev_next  = 1'b1;
      ec_next  = ISSD_EXC_SYSTEM_TRAP_INSTR;
      epc_next = instr_pc;
    end
  end

  // exception registers
  always_ff @(posedge clock) begin
    if (srst) begin
      ev_reg    <= 1'b0;
      ec_reg    <= ISSD_EXC_NONE;
      epc_reg   <= 32'h0000_0000;
    end else begin
      ev_reg    <= ev_next;
      ec_reg    <= ec_next;
      epc_reg   <= epc_next;
    end
  end

  // outputs straight from flip-flops
  assign instr_ready         = ready_reg;
  assign gpr_we              = we_reg;
  assign gpr_waddr           = waddr_reg;
  assign gpr_wdata           = wdata_reg;
  assign store_valid         = sv_reg;
  assign store_vaddr         = va_reg;
  assign store_paddr_low     = pa_reg;
  assign store_data          = sd_reg;
  assign store_byte_en       = be_reg;
  assign store_size          = sz_reg;
  assign exc_valid           = ev_reg;
  assign exc_code            = ec_reg;
  assign exception_return_pc = epc_reg;
endmodule : issd_decode

//--- design/issd_pkg.sv
// package: opcode maps, field positions and store sizes for the decoder
package issd_pkg;
  // primary opcode, function and register field positions
  localparam int OP_HI  = 31;
  localparam int OP_LO  = 26;
  localparam int FN_HI  = 5;
  localparam int FN_LO  = 0;
  localparam int RS_LO  = 21;
  localparam int RT_LO  = 16;
  localparam int RD_LO  = 11;
  // primary opcodes
  localparam logic [5:0] OP_FUNC_GROUP  = 6'h00;
  localparam logic [5:0] OP_BRANCH_COND = 6'h01;
  localparam logic [5:0] OP_XOR_IMM     = 6'h0e;
  localparam logic [5:0] OP_STORE_LEFT  = 6'h2a;
  localparam logic [5:0] OP_STORE_RIGHT = 6'h2e;
  // function field codes
  localparam logic [5:0] FN_SYS_TRAP = 6'h0c;
  localparam logic [5:0] FN_BARRIER  = 6'h0f;
  localparam logic [5:0] FN_XOR_REG  = 6'h26;
  // reserved rows 6 and 7 of the primary map, columns 1 to 3
  localparam logic [2:0] ROW_COPROC_LOAD  = 3'h6;
  localparam logic [2:0] ROW_COPROC_STORE = 3'h7;
  localparam logic [2:0] COL_COPROC_FIRST = 3'h1;
  localparam logic [2:0] COL_COPROC_LAST  = 3'h3;
  // full word store size in bytes
  localparam logic [2:0] WORD_BYTES = 3'h4;
  // exception codes
  typedef enum logic [1:0] {
    ISSD_EXC_NONE     = 2'h0,
    ISSD_EXC_SYSTEM_TRAP_INSTR  = 2'h1,
    ISSD_EXC_RESERVED = 2'h2
  } issd_exc_t;
endpackage : issd_pkg

//--- design/issd_reserved_check.sv
// reserved-encoding classifier for the primary and function maps
`timescale 1ns/1ns
module issd_reserved_check
  import issd_pkg::*;
(
  input  wire logic [31:0] instr,
  output logic             reserved
);
  logic [2:0] row;
  logic [2:0] col;
  logic [5:0] fn;

  // primary map row/column and function field
  assign row = instr[31:29];
  assign col = instr[28:26];
  assign fn  = instr[FN_HI:FN_LO];

  // star entries raise, gamma and phi entries (sub-maps, cp0) do not
  always_comb begin
    reserved = 1'b0;
    case (row)
      3'h3: reserved = (col != 3'h4);
      3'h4: reserved = (col == 3'h7);
      3'h5: reserved = (col == 3'h4) || (col == 3'h5);
      3'h6, 3'h7: reserved = 1'b1;
      3'h1: reserved = (col == 3'h4);
      // coprocessor 0 with the function bit set: only one star entry
      3'h2: reserved = (col == 3'h0) && instr[25] && (fn == 6'h18);
      3'h0: begin
        if (col == 3'h0) begin
          case (fn[5:3])
            3'h0: reserved = (fn[2:0] == 3'h1) || (fn[2:0] == 3'h5);
            3'h1: reserved = (fn[2:0] == 3'h2) || (fn[2:0] == 3'h3);
            3'h2, 3'h3: reserved = fn[2];
            3'h4: reserved = 1'b0;
            3'h5: reserved = !(fn[2:0] == 3'h2 || fn[2:0] == 3'h3);
            default: reserved = 1'b1;
          endcase
        end
      end
      default: reserved = 1'b0;
    endcase
  end
endmodule : issd_reserved_check

//--- design/issd_store_align.sv
// partial-word store lane and data formation
`timescale 1ns/1ns
module issd_store_align
  import issd_pkg::*;
(
  input  wire logic        is_left,
  input  wire logic [1:0]  byte_idx,
  input  wire logic [31:0] src,
  output logic [31:0]      data,
  output logic [3:0]       byte_en,
  output logic [2:0]       size
);
  // left: top register byte lands in lane idx, so shift right by 8*(3-idx)
  // and write idx+1 bytes; right: shift left by 8*idx, 4-idx bytes
  always_comb begin
    if (is_left) begin
      data    = src >> {2'h3 - byte_idx, 3'b000};
      size    = {1'b0, byte_idx} + 3'h1;
      byte_en = 4'hf >> (2'h3 - byte_idx);
    end else begin
      data    = src << {byte_idx, 3'b000};
      size    = WORD_BYTES - {1'b0, byte_idx};
      byte_en = 4'hf << byte_idx;
    end
  end
endmodule : issd_store_align

//--- tb/issd_decode_sva.sv
// checker: timing and value relations at the decoder ports
`timescale 1ns/1ns
module issd_decode_sva
  import issd_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [31:0] instr,
  input wire logic [31:0] rs_value,
  input wire logic [31:0] rt_value,
  input wire logic        mem_ops_pending,
  input wire logic        store_ready,
  input wire logic        gpr_we,
  input wire logic [31:0] gpr_wdata,
  input wire logic        store_valid,
  input wire logic [31:0] store_data,
  input wire logic [3:0]  store_byte_en,
  input wire logic [2:0]  store_size,
  input wire logic        exc_valid,
  input wire issd_pkg::issd_exc_t exc_code
);
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (srst);
  // accepted instruction and its map fields
  wire       take = instr_valid && instr_ready;
  wire [5:0] op   = instr[31:26];
  wire       fgrp = take && op == OP_FUNC_GROUP;
  xor_reg_a: assert property (
    fgrp && instr[5:0] == FN_XOR_REG |=> gpr_we &&
    gpr_wdata == $past(rs_value ^ rt_value)) else $error("bad xor result");
  xor_imm_a: assert property (
    take && op == OP_XOR_IMM |=> gpr_we && gpr_wdata ==
    ($past(rs_value) ^ {16'h0, $past(instr[15:0])})) else $error("bad exclusive_or_immediate");
  sys_trap_a: assert property (
    fgrp && instr[5:0] == FN_SYS_TRAP |=> exc_valid && !gpr_we &&
    exc_code == ISSD_EXC_SYSTEM_TRAP_INSTR) else $error("trap not raised");
  rsv_row_a: assert property (
    take && instr[31:29] >= ROW_COPROC_LOAD |=> exc_valid &&
    exc_code == ISSD_EXC_RESERVED) else $error("row 6/7 not reserved");
  barrier_stall_a: assert property (
    fgrp && instr[5:0] == FN_BARRIER |=> !instr_ready)
    else $error("barrier did not stall");
  barrier_hold_a: assert property (
    !instr_ready && mem_ops_pending && !store_valid |=> !instr_ready)
    else $error("released while memory busy");
  store_hold_a: assert property (
    store_valid && !store_ready |=> store_valid && $stable(store_data) &&
    $stable(store_byte_en)) else $error("store changed while waiting");
  store_left_a: assert property (
    take && op == OP_STORE_LEFT |=> store_valid && !exc_valid &&
    store_byte_en[0] && $countones(store_byte_en) == store_size &&
    store_data == ($past(rt_value) >> (8 * (WORD_BYTES - store_size))))
    else $error("bad left store");
  store_right_a: assert property (
    take && op == OP_STORE_RIGHT |=> store_valid && !exc_valid &&
    store_byte_en[3] && $countones(store_byte_en) == store_size &&
    store_data == ($past(rt_value) << (8 * (WORD_BYTES - store_size))))
    else $error("bad right store");
  // main scenarios reached
  cover property (store_valid && !store_ready ##1 store_ready);
  cover property (exc_valid && exc_code == ISSD_EXC_SYSTEM_TRAP_INSTR);
  cover property (!instr_ready && mem_ops_pending ##1 !mem_ops_pending);
endmodule : issd_decode_sva

bind issd_decode issd_decode_sva issd_decode_sva_inst (.clock, .srst,
  .instr_valid, .instr_ready, .instr, .rs_value, .rt_value, .mem_ops_pending,
  .store_ready, .gpr_we, .gpr_wdata, .store_valid, .store_data,
  .store_byte_en, .store_size, .exc_valid, .exc_code);

//--- tb/issd_decode_test.sv
// self-checking bench for the partial-store, barrier, trap and xor decoder
`timescale 1ns/1ns
module issd_decode_test;
  import issd_pkg::*;
  typedef struct packed {
    logic [31:0] ins;
    logic        we;
    logic [31:0] wd;
    issd_exc_t   exc;
  } issd_row_t;
  localparam logic [31:0] A = 32'hf0f01234;
  localparam logic [31:0] B = 32'h0ff08765;
  logic        clock = 0, srst = 1, instr_valid = 0, load_go = 0;
  logic [31:0] instr = 0, instr_pc = 32'h100, rs_value = A, rt_value = B;
  logic        cpu_big_endian_flag = 0, reverse_endian_flag = 0;
  logic        memory_big_endian_flag = 0;
  logic [1:0]  paddr_low = 0, store_paddr_low, ix;
  logic [3:0]  delay = 0, store_byte_en, ee;
  logic        instr_ready, gpr_we, store_valid, store_ready, exc_valid;
  logic        mem_ops_pending;
  logic [4:0]  gpr_waddr;
  logic [31:0] gpr_wdata, store_vaddr, store_data, exception_return_pc;
  logic [31:0] mem_word, exp_mem = 0, ed;
  logic [2:0]  store_size;
  issd_exc_t   exc_code;
  int          fail_count = 0, checks = 0;
  // instruction, write expected, result, exception expected
  issd_row_t rows [12] = '{
    '{32'h00221826, 1'b1, A ^ B, ISSD_EXC_NONE},
    '{32'h38228001, 1'b1, A ^ 32'h8001, ISSD_EXC_NONE},
    '{32'h03ffffcc, 1'b0, 32'h0, ISSD_EXC_SYSTEM_TRAP_INSTR},
    '{32'h60000000, 1'b0, 32'h0, ISSD_EXC_RESERVED},
    '{32'h00000001, 1'b0, 32'h0, ISSD_EXC_RESERVED},
    '{32'h04040000, 1'b0, 32'h0, ISSD_EXC_NONE},
    '{32'h42000001, 1'b0, 32'h0, ISSD_EXC_NONE},
    '{32'h42000008, 1'b0, 32'h0, ISSD_EXC_NONE},
    '{32'h70000002, 1'b0, 32'h0, ISSD_EXC_NONE},
    '{32'h00000005, 1'b0, 32'h0, ISSD_EXC_RESERVED},
    '{32'h42000018, 1'b0, 32'h0, ISSD_EXC_RESERVED},
    '{32'h0000000f, 1'b0, 32'h0, ISSD_EXC_NONE}};

  issd_decode issd_decode_inst (.clock, .srst, .instr_valid, .instr,
    .instr_pc, .rs_value, .rt_value, .paddr_low, .cpu_big_endian_flag,
    .reverse_endian_flag, .memory_big_endian_flag, .mem_ops_pending,
    .store_ready, .instr_ready, .gpr_we, .gpr_waddr, .gpr_wdata, .store_valid,
    .store_vaddr, .store_paddr_low, .store_data, .store_byte_en, .store_size,
    .exc_valid, .exc_code, .exception_return_pc);
  issd_mem_model issd_mem_model_inst (.clock, .srst, .store_valid,
    .store_byte_en, .store_data, .delay, .load_go, .store_ready,
    .mem_ops_pending, .mem_word);

  // 50 ns period
  always #25 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // offer one instruction after an idle cycle; returns in the answer cycle
  task automatic issue(input logic [31:0] ins);
    @(negedge clock);
    instr = ins;
    instr_pc = instr_pc + 32'h4;
    instr_valid = 1;
    repeat (30) if (instr_ready !== 1'b1) @(negedge clock);
    check(instr_ready, 1);
    @(negedge clock);
    instr_valid = 0;
  endtask : issue

  task automatic finish_test;
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // reset, table, reserved rows, stores, barrier
  initial begin
    repeat (4) @(negedge clock);
    check({instr_ready, gpr_we, store_valid, exc_valid}, 0);
    srst = 0;
    foreach (rows[i]) begin
      issue(rows[i].ins);
      check(gpr_we, rows[i].we);
      check(gpr_wdata & {32{rows[i].we}}, rows[i].wd);
      if (rows[i].we) check(gpr_waddr, rows[i].ins[31:26] ? 2 : 3);
      check(exc_valid, rows[i].exc != 0);
      if (rows[i].exc != ISSD_EXC_NONE) begin
        check(exc_code, rows[i].exc);
        check(exception_return_pc, instr_pc);
      end
    end
    for (int r = 6; r < 8; r++)
      for (int c = 1; c < 4; c++) begin
        issue({r[2:0], c[2:0], 26'h0});
        check({exc_valid, exc_code}, {1'b1, ISSD_EXC_RESERVED});
      end
    rs_value = 32'h1004;
    for (int k = 0; k < 32; k++) begin
      {cpu_big_endian_flag, reverse_endian_flag, paddr_low} = k[3:0];
      memory_big_endian_flag = k[0] ^ k[4];
      delay = {2'h0, k[1:0]};
      ix = k[1:0] ^ {2{k[3]}};
      ed = k[4] ? B >> (8 * (3 - ix)) : B << (8 * ix);
      ee = k[4] ? 4'hf >> (2'h3 - ix) : 4'hf << ix;
      issue({k[4] ? OP_STORE_LEFT : OP_STORE_RIGHT, 10'h022, 14'h3fff,
             k[1:0]});
      check({store_valid, exc_valid}, 2'h2);
      check(store_vaddr, 32'h1000 + k[1:0]);
      check(store_data, ed);
      check(store_byte_en, ee);
      check(store_size, $countones(ee));
      check(store_paddr_low, memory_big_endian_flag ?
            paddr_low ^ {2{reverse_endian_flag}} : 2'h0);
      for (int b = 0; b < 4; b++)
        if (ee[b]) exp_mem[8*b+:8] = ed[8*b+:8];
      repeat (8) if (store_valid === 1'b1) @(negedge clock);
      check(instr_ready, 1);
      check(mem_word, exp_mem);
    end
    rs_value = A;
    delay = 4'h6;
    load_go = 1;
    @(negedge clock);
    load_go = 0;
    issue(32'h00221826);
    check(gpr_we, 1);
    issue(32'h0000000f);
    check({instr_ready, mem_ops_pending}, 2'h1);
    repeat (20) if (instr_ready !== 1'b1) @(negedge clock);
    check({instr_ready, mem_ops_pending}, 2'h2);
    // reset in mid-run drops a store that is still waiting
    issue({OP_STORE_RIGHT, 10'h022, 16'h0000});
    check(store_valid, 1);
    srst = 1;
    @(negedge clock);
    check({instr_ready, gpr_we, store_valid, exc_valid}, 0);
    srst = 0;
    @(negedge clock);
    check({instr_ready, store_valid}, 2'h2);
    finish_test;
  end

  // about twenty times the expected run length
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
endmodule : issd_decode_test

//--- tb/issd_mem_model.sv
// store-path model: delayed store accept, byte-lane memory word, load tracker
`timescale 1ns/1ns
module issd_mem_model (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        store_valid,
  input  wire logic [3:0]  store_byte_en,
  input  wire logic [31:0] store_data,
  input  wire logic [3:0]  delay,
  input  wire logic        load_go,
  output logic             store_ready,
  output logic             mem_ops_pending,
  output logic [31:0]      mem_word
);
  logic [3:0] wait_reg;
  logic [3:0] load_reg;
  // accept only after the store has waited delay cycles
  assign store_ready = store_valid && (wait_reg == delay);
  assign mem_ops_pending = (load_reg != 4'h0);
  // wait counter, outstanding load countdown, lane-wise word update
  always_ff @(posedge clock) begin
    if (srst) begin
      wait_reg <= 4'h0;
      load_reg <= 4'h0;
      mem_word <= 32'h0;
    end else begin
      wait_reg <= (store_valid && !store_ready) ? wait_reg + 4'h1 : 4'h0;
      if (load_go)
        load_reg <= delay;
      else if (load_reg != 4'h0)
        load_reg <= load_reg - 4'h1;
      for (int b = 0; b < 4; b++)
        if (store_ready && store_byte_en[b])
          mem_word[8*b+:8] <= store_data[8*b+:8];
    end
  end
endmodule : issd_mem_model
